// ===== pkg/ecp_params.svh
// register indexes, field positions, reset values and pin order of the canceller pin control
// assumes inclusion by bare name from the design files
`ifndef ECP_PARAMS_SVH
`define ECP_PARAMS_SVH
`define ECP_REG_AW          4
`define ECP_REG_DW          8
`define ECP_IDX_CTRL1       4'h0
`define ECP_IDX_CTRL2       4'h1
`define ECP_IDX_STATUS      4'h2
`define ECP_CTRL1_RST       8'h0f
`define ECP_CTRL2_RST       8'h00
`define ECP_F_STATE_A       1:0
`define ECP_F_STATE_B       3:2
`define ECP_F_SUPP_OFF      0
`define ECP_F_REV_OFF       1
`define ECP_UP_CMD_BITS     5'h08
`define ECP_UP_FRAME_BITS   5'h10
`define ECP_UP_READ_BIT     7
`define ECP_PCM_WORD_BITS   8
`define ECP_NUM_PINS        15
`define ECP_P_STANDBY_N     0
`define ECP_P_SUPP          1
`define ECP_P_PHASE         2
`define ECP_P_CODE          3
`define ECP_P_STRAP_A       4
`define ECP_P_STRAP_B       5
`define ECP_P_SEL_A_LO      6
`define ECP_P_SEL_A_HI      7
`define ECP_P_SEL_B_LO      8
`define ECP_P_SEL_B_HI      9
`define ECP_P_SINGLE_WIRE   10
`define ECP_P_PCM_CLK       11
`define ECP_P_SEND_PCM      12
`define ECP_P_EN_A          13
`define ECP_P_EN_B          14
`endif

// ===== pkg/ecp_pkg.sv
// types shared by the canceller pin control modules
// assumes ecp_params.svh for the numeric constants
package ecp_pkg;
  typedef enum logic [1:0] {
    ECP_ST_MUTE,
    ECP_ST_BYPASS,
    ECP_ST_ADAPT_OFF,
    ECP_ST_ADAPT_ON
  } ecp_state_e;

  typedef enum logic [1:0] {
    ECP_UP_IDLE,
    ECP_UP_CMD,
    ECP_UP_DATA
  } ecp_up_e;
endpackage

// ===== pkg/ecp_sync_if.sv
// carries raw pin levels into the synchroniser bank and the synchronised levels back
// assumes one core clock for both ends
interface ecp_sync_if #(parameter int N = 15);
  logic [N-1:0] raw;
  logic [N-1:0] sync;
  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface

// ===== hw/ecp_sync.sv
// two-flop synchroniser bank for every pin input of the pin control block
// assumes all raw levels are asynchronous to core_clk_i
module ecp_sync #(
  parameter int N = 15
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  ecp_sync_if.snk   pins
);
  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pins.raw;
      sync_reg <= meta_reg;
    end
  end

  assign pins.sync = sync_reg;
endmodule

// ===== hw/ecp_pin_ctrl.sv
// pin control and pin multiplexing of a dual voice echo canceller
// assumes the canceller datapath supplies tone detects on core_clk_i; all pins are asynchronous
//
// The address-and-strobe port and the address map were decided locally.
`include "ecp_params.svh"

module ecp_pin_ctrl #(
  parameter int PCM_W = `ECP_PCM_WORD_BITS
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   standby_reset_n_i,
  input  wire logic                   suppressor_enable_pin_i,
  input  wire logic                   tone_phase_select_i,
  input  wire logic                   code_select_i,
  input  wire logic                   mode_strap_a_i,
  input  wire logic                   mode_strap_b_i,
  input  wire logic                   state_sel_a_lo_i,
  input  wire logic                   state_sel_a_hi_i,
  input  wire logic                   state_sel_b_lo_i,
  input  wire logic                   state_sel_b_hi_i,
  input  wire logic                   single_wire_i,
  output logic                        microport_out_line_o,
  output logic                        microport_out_line_oe_o,
  input  wire logic                   pcm_bit_clk_i,
  input  wire logic                   send_pcm_i,
  input  wire logic                   pcm_enable_a_i,
  input  wire logic                   pcm_enable_b_i,
  output logic [1:0][PCM_W-1:0]       send_word_o,
  output logic [1:0]                  send_word_valid_o,
  input  wire logic                   tone_det_a_i,
  input  wire logic                   tone_det_b_i,
  output logic                        tone_flag_a_n_o,
  output logic                        tone_flag_b_n_o,
  output logic                        suppressor_en_o,
  output logic                        reversal_required_o,
  output logic                        sign_mag_code_o,
  output ecp_pkg::ecp_state_e         state_a_o,
  output ecp_pkg::ecp_state_e         state_b_o,
  output logic                        controller_mode_o,
  output logic                        standby_o,
  input  wire logic [`ECP_REG_AW-1:0] reg_addr_i,
  input  wire logic [`ECP_REG_DW-1:0] reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [`ECP_REG_DW-1:0]      reg_rdata_o
);
  import ecp_pkg::*;

  ecp_sync_if #(.N(`ECP_NUM_PINS)) pins ();

  logic                      rst;
  logic [`ECP_NUM_PINS-1:0]  s;
  logic                      ctrl_mode;
  logic [`ECP_REG_DW-1:0]    ctrl1_reg;
  logic [`ECP_REG_DW-1:0]    ctrl2_reg;
  logic [`ECP_REG_DW-1:0]    status;
  logic                      sclk_d_reg;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      up_active;
  logic                      up_din;
  ecp_up_e                   up_state_reg;
  logic [4:0]                bit_cnt_reg;
  logic [7:0]                cmd_reg;
  logic [7:0]                dat_reg;
  logic [7:0]                sh_reg;
  logic                      up_wr;
  logic [`ECP_REG_AW-1:0]    up_addr;
  logic [7:0]                up_wdata;
  logic                      pcm_clk_d_reg;
  logic                      pcm_rise;
  logic                      flag_a_n_reg;
  logic                      flag_b_n_reg;

  assign pins.raw = {pcm_enable_b_i, pcm_enable_a_i, send_pcm_i, pcm_bit_clk_i, single_wire_i,
                     state_sel_b_hi_i, state_sel_b_lo_i, state_sel_a_hi_i, state_sel_a_lo_i,
                     mode_strap_b_i, mode_strap_a_i, code_select_i, tone_phase_select_i,
                     suppressor_enable_pin_i, standby_reset_n_i};

  ecp_sync #(.N(`ECP_NUM_PINS)) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .pins       (pins)
  );

  assign s = pins.sync;

  // standby holds every register past the synchronisers in reset
  assign rst       = reset_i | ~s[`ECP_P_STANDBY_N];
  assign standby_o = ~s[`ECP_P_STANDBY_N];

  assign ctrl_mode = ~s[`ECP_P_STRAP_A] & ~s[`ECP_P_STRAP_B];
  assign controller_mode_o = ctrl_mode;

  // pin or register source per operating mode; code select comes from its pin in both modes
  assign suppressor_en_o = ctrl_mode ? ~ctrl2_reg[`ECP_F_SUPP_OFF]
                                     : s[`ECP_P_SUPP];
  assign reversal_required_o = ctrl_mode ? ~ctrl2_reg[`ECP_F_REV_OFF]
                                         : s[`ECP_P_PHASE];
  assign sign_mag_code_o = ~s[`ECP_P_CODE];

  assign state_a_o = ctrl_mode ? ecp_state_e'(ctrl1_reg[`ECP_F_STATE_A])
                               : ecp_state_e'({s[`ECP_P_SEL_A_HI], s[`ECP_P_SEL_A_LO]});
  assign state_b_o = ctrl_mode ? ecp_state_e'(ctrl1_reg[`ECP_F_STATE_B])
                               : ecp_state_e'({s[`ECP_P_SEL_B_HI], s[`ECP_P_SEL_B_LO]});

  // tone flags follow the detectors and stay high through reset
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      flag_a_n_reg <= 1'b1;
      flag_b_n_reg <= 1'b1;
    end else begin
      flag_a_n_reg <= ~tone_det_a_i;
      flag_b_n_reg <= ~tone_det_b_i;
    end
  end

  assign tone_flag_a_n_o = flag_a_n_reg;
  assign tone_flag_b_n_o = flag_b_n_reg;

  assign status = {4'h0, sign_mag_code_o, ctrl_mode, ~flag_b_n_reg, ~flag_a_n_reg};

  function automatic logic [7:0] reg_value(input logic [`ECP_REG_AW-1:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `ECP_IDX_CTRL1:  v = ctrl1_reg;
      `ECP_IDX_CTRL2:  v = ctrl2_reg;
      `ECP_IDX_STATUS: v = status;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // microport pins: B pair is clock and select, A pair carries data
  assign up_active = ctrl_mode & ~s[`ECP_P_SEL_B_LO];
  assign up_din    = s[`ECP_P_SINGLE_WIRE] ? s[`ECP_P_SEL_A_LO]
                                           : s[`ECP_P_SEL_A_HI];
  assign sclk_rise = s[`ECP_P_SEL_B_HI] & ~sclk_d_reg;
  assign sclk_fall = ~s[`ECP_P_SEL_B_HI] & sclk_d_reg;

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= s[`ECP_P_SEL_B_HI];
    end
  end

  // frame sequencing: eight command bits then eight data bits
  always_ff @(posedge core_clk_i) begin
    if (rst || !up_active) begin
      up_state_reg <= ECP_UP_IDLE;
      bit_cnt_reg  <= 5'h00;
    end else begin
      case (up_state_reg)
        ECP_UP_IDLE: begin
          up_state_reg <= ECP_UP_CMD;
        end
        ECP_UP_CMD: begin
          if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == `ECP_UP_CMD_BITS - 5'h01) begin
              up_state_reg <= ECP_UP_DATA;
            end
          end
        end
        ECP_UP_DATA: begin
          if (sclk_rise && bit_cnt_reg != `ECP_UP_FRAME_BITS) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
        default: begin
          up_state_reg <= ECP_UP_IDLE;
        end
      endcase
    end
  end

  // command and write data shift in on rising host clock edges
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      cmd_reg <= 8'h00;
      dat_reg <= 8'h00;
    end else if (up_active && sclk_rise) begin
      if (up_state_reg == ECP_UP_CMD) begin
        cmd_reg <= {cmd_reg[6:0], up_din};
      end else if (up_state_reg == ECP_UP_DATA) begin
        dat_reg <= {dat_reg[6:0], up_din};
      end
    end
  end

  // the last data bit of a write frame commits the register
  assign up_wr = up_active && sclk_rise && up_state_reg == ECP_UP_DATA
                 && bit_cnt_reg == `ECP_UP_FRAME_BITS - 5'h01
                 && !cmd_reg[`ECP_UP_READ_BIT];
  assign up_addr  = cmd_reg[`ECP_REG_AW-1:0];
  assign up_wdata = {dat_reg[6:0], up_din};

  // read data leaves on falling host clock edges
  always_ff @(posedge core_clk_i) begin
    if (rst || !up_active) begin
      sh_reg                  <= 8'h00;
      microport_out_line_o    <= 1'b0;
      microport_out_line_oe_o <= 1'b0;
    end else if (up_state_reg == ECP_UP_CMD && sclk_rise
                 && bit_cnt_reg == `ECP_UP_CMD_BITS - 5'h01) begin
      sh_reg <= reg_value({cmd_reg[`ECP_REG_AW-2:0], up_din});
    end else if (up_state_reg == ECP_UP_DATA && sclk_fall
                 && bit_cnt_reg != `ECP_UP_FRAME_BITS && cmd_reg[`ECP_UP_READ_BIT]) begin
      microport_out_line_o    <= sh_reg[7];
      microport_out_line_oe_o <= 1'b1;
      sh_reg                  <= {sh_reg[6:0], 1'b0};
    end
  end

  // control registers: the parallel port wins a same-cycle collision
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      ctrl1_reg <= `ECP_CTRL1_RST;
      ctrl2_reg <= `ECP_CTRL2_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ECP_IDX_CTRL1) begin
        ctrl1_reg <= reg_wdata_i;
      end
      if (reg_addr_i == `ECP_IDX_CTRL2) begin
        ctrl2_reg <= reg_wdata_i;
      end
    end else if (up_wr) begin
      if (up_addr == `ECP_IDX_CTRL1) begin
        ctrl1_reg <= up_wdata;
      end
      if (up_addr == `ECP_IDX_CTRL2) begin
        ctrl2_reg <= up_wdata;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= reg_value(reg_addr_i);
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // send-path PCM: one enable strobe per canceller channel
  assign pcm_rise = s[`ECP_P_PCM_CLK] & ~pcm_clk_d_reg;

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      pcm_clk_d_reg <= 1'b0;
    end else begin
      pcm_clk_d_reg <= s[`ECP_P_PCM_CLK];
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic             en;
    logic             en_d_reg;
    logic             got_reg;
    logic [PCM_W-1:0] sh_reg;
    logic [PCM_W-1:0] word_reg;
    logic             valid_reg;

    assign en = (ch == 0) ? s[`ECP_P_EN_A] : s[`ECP_P_EN_B];

    always_ff @(posedge core_clk_i) begin
      if (rst) begin
        en_d_reg  <= 1'b0;
        got_reg   <= 1'b0;
        sh_reg    <= '0;
        word_reg  <= '0;
        valid_reg <= 1'b0;
      end else begin
        en_d_reg  <= en;
        valid_reg <= 1'b0;
        if (en && pcm_rise) begin
          sh_reg  <= {sh_reg[PCM_W-2:0], s[`ECP_P_SEND_PCM]};
          got_reg <= 1'b1;
        end
        // strobe fall closes the channel word
        if (!en && en_d_reg && got_reg) begin
          word_reg  <= sh_reg;
          valid_reg <= 1'b1;
          got_reg   <= 1'b0;
        end
      end
    end

    assign send_word_o[ch]       = word_reg;
    assign send_word_valid_o[ch] = valid_reg;
  end
endmodule

// ===== test/ecp_host.sv
// host microcontroller model driving the serial microport
// assumes a 48 ns bit clock that runs only inside frames
module ecp_host (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      tx_o,
  input  wire logic rx_i,
  input  wire logic single_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    tx_o = 1'b0;
  end
  // command byte then data byte, msb first; sel low keeps the frame unselected
  task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input logic sel, output logic [7:0] got);
    logic [15:0] sh;
    sh = {cmd, dat};
    got = 8'h00;
    cs_n_o = !sel;
    #24;
    for (int i = 0; i < 16; i++) begin
      // single-wire read: the host holds tx_o high; two-wire read: it toggles tx_o each bit
      tx_o = (cmd[7] && i > 7) ? (single_i || !tx_o) : sh[15 - i];
      #24 sclk_o = 1'b1;
      if (i > 7) got = {got[6:0], rx_i};
      #24 sclk_o = 1'b0;
    end
    #24 cs_n_o = 1'b1;
    tx_o = !tx_o;
    #48;
  endtask
endmodule

// ===== test/ecp_pin_ctrl_chk.sv
// port assertions of the canceller pin control
// assumes bind into ecp_pin_ctrl; pins judged only after three steady cycles
module ecp_pin_ctrl_chk (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic suppressor_enable_pin_i,
  input wire logic tone_phase_select_i,
  input wire logic code_select_i,
  input wire logic mode_strap_a_i,
  input wire logic mode_strap_b_i,
  input wire logic state_sel_a_hi_i,
  input wire logic state_sel_a_lo_i,
  input wire logic state_sel_b_hi_i,
  input wire logic state_sel_b_lo_i,
  input wire logic tone_det_a_i,
  input wire logic tone_det_b_i,
  input wire logic tone_flag_a_n_o,
  input wire logic tone_flag_b_n_o,
  input wire logic suppressor_en_o,
  input wire logic reversal_required_o,
  input wire logic sign_mag_code_o,
  input wire ecp_pkg::ecp_state_e state_a_o,
  input wire ecp_pkg::ecp_state_e state_b_o,
  input wire logic controller_mode_o,
  input wire logic standby_o
);
  import ecp_pkg::*;
  logic [8:0] pins_w, hold_w, d1_reg, d2_reg, d3_reg;
  logic [2:0] age_reg;
  logic       calm_w, strap_w;
  assign pins_w = {suppressor_enable_pin_i, tone_phase_select_i, code_select_i, mode_strap_a_i, mode_strap_b_i,
                   state_sel_a_hi_i, state_sel_a_lo_i, state_sel_b_hi_i, state_sel_b_lo_i};
  assign hold_w = ~((d1_reg ^ d2_reg) | (d2_reg ^ d3_reg));
  assign calm_w = (age_reg == 3'h4) && !standby_o && (hold_w[5:4] == 2'h3);
  assign strap_w = calm_w && (d2_reg[5:4] != 2'h0);
  always_ff @(posedge core_clk_i) begin
    d1_reg <= pins_w;
    d2_reg <= d1_reg;
    d3_reg <= d2_reg;
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      age_reg <= 3'h0;
    end else if (age_reg != 3'h4) begin
      age_reg <= age_reg + 3'h1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  AST_MODE: assert property (calm_w |-> controller_mode_o == (d2_reg[5:4] == 2'h0))
    else $error("mode not decoded from both straps");
  AST_CODE: assert property (calm_w && hold_w[6] |-> sign_mag_code_o == !d2_reg[6])
    else $error("code select not followed");
  AST_SUPP: assert property (strap_w && hold_w[8] |-> suppressor_en_o == d2_reg[8])
    else $error("suppressor enable not taken from pin");
  AST_REV: assert property (strap_w && hold_w[7] |-> reversal_required_o == d2_reg[7])
    else $error("phase reversal need not taken from pin");
  AST_STATE: assert property (strap_w && hold_w[3:0] == 4'hf |-> {state_a_o, state_b_o} == d2_reg[3:0])
    else $error("canceller state not taken from pins");
  AST_FLAG_A: assert property (!standby_o |=> tone_flag_a_n_o == !$past(tone_det_a_i))
    else $error("flag a does not follow detector a");
  AST_FLAG_B: assert property (!standby_o |=> tone_flag_b_n_o == !$past(tone_det_b_i))
    else $error("flag b does not follow detector b");
  AST_STBY_FLAGS: assert property (standby_o [*2] |-> tone_flag_a_n_o && tone_flag_b_n_o)
    else $error("flags active in standby");
  COV_CTRL: cover property ($rose(controller_mode_o));
  COV_TONE: cover property ($fell(tone_flag_b_n_o));
  COV_STBY: cover property (standby_o [*2]);
endmodule
bind ecp_pin_ctrl ecp_pin_ctrl_chk ecp_pin_ctrl_chk_i (.*);

// ===== test/ecp_pin_ctrl_bench.sv
// self-checking bench of the canceller pin control
// assumes the host model on the microport and an lfsr for random pin values
`include "ecp_params.svh"
module ecp_pin_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ecp_pkg::*;
  logic core_clk_i, reset_i, standby_reset_n_i, suppressor_enable_pin_i, tone_phase_select_i, code_select_i;
  logic mode_strap_a_i, mode_strap_b_i, single_wire_i, pcm_bit_clk_i, send_pcm_i, pcm_enable_a_i, pcm_enable_b_i;
  logic tone_det_a_i, tone_det_b_i, reg_wr_i, reg_rd_i, host_on, microport_out_line_o, microport_out_line_oe_o;
  logic tone_flag_a_n_o, tone_flag_b_n_o, suppressor_en_o, reversal_required_o, sign_mag_code_o;
  logic controller_mode_o, standby_o;
  logic [3:0] reg_addr_i, sel_pins;
  logic [7:0] reg_wdata_i, reg_rdata_o, rnd, rd, c1, c2;
  logic [1:0][7:0] send_word_o;
  logic [1:0] send_word_valid_o;
  ecp_state_e state_a_o, state_b_o;
  wire state_sel_a_lo_i, state_sel_a_hi_i, state_sel_b_lo_i, state_sel_b_hi_i, sclk, cs_n, tx;
  int fail_count, checks_done;
  // the shared data pin: device while enabled, otherwise host or strap level
  assign state_sel_a_lo_i = microport_out_line_oe_o ? microport_out_line_o : host_on ? tx : sel_pins[2];
  assign state_sel_a_hi_i = host_on ? tx : sel_pins[3];
  assign state_sel_b_lo_i = host_on ? cs_n : sel_pins[0];
  assign state_sel_b_hi_i = host_on ? sclk : sel_pins[1];
  ecp_pin_ctrl ecp_pin_ctrl_i (.*);
  ecp_host ecp_host_i (.sclk_o(sclk), .cs_n_o(cs_n), .tx_o(tx), .rx_i(state_sel_a_lo_i), .single_i(single_wire_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [7:0] view();
    return {controller_mode_o, suppressor_en_o, reversal_required_o, sign_mag_code_o, state_a_o, state_b_o};
  endfunction
  function automatic logic [7:0] expect_view(input logic [7:0] r, input logic ctl);
    return {ctl, ctl ? !c2[0] : r[2], ctl ? !c2[1] : r[1], !r[0], ctl ? {c1[1:0], c1[3:2]} : r[6:3]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
    @(posedge core_clk_i);
  endtask
  task automatic pcm_word(input int ch, input logic [7:0] d);
    int n;
    {pcm_enable_b_i, pcm_enable_a_i} = (ch == 1) ? 2'b10 : 2'b01;
    for (int i = 0; i < 8; i++) begin
      send_pcm_i = d[7 - i];
      #24 pcm_bit_clk_i = 1'b1;
      #24 pcm_bit_clk_i = 1'b0;
    end
    {pcm_enable_b_i, pcm_enable_a_i} = 2'b00;
    send_pcm_i = !send_pcm_i;
    n = 0;
    while (send_word_valid_o[ch] !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    if (send_word_valid_o[ch] !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t no word on pcm channel", $time);
      tally_and_finish();
    end else begin
      check(send_word_o[ch], d);
    end
    @(posedge core_clk_i);
  endtask
  initial begin
    fail_count = 0;
    checks_done = 0;
    rnd = 8'h0c;
    {reset_i, standby_reset_n_i, host_on, single_wire_i, pcm_bit_clk_i, send_pcm_i} = 6'b110000;
    {pcm_enable_a_i, pcm_enable_b_i, tone_det_a_i, tone_det_b_i, reg_wr_i, reg_rd_i} = 6'b0;
    {suppressor_enable_pin_i, tone_phase_select_i, code_select_i, mode_strap_a_i, mode_strap_b_i} = 5'b11110;
    {reg_addr_i, reg_wdata_i, sel_pins, c2} = '0;
    c1 = `ECP_CTRL1_RST;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    reg_rd(`ECP_IDX_CTRL1, rd);
    check(rd, `ECP_CTRL1_RST);
    reg_rd(`ECP_IDX_CTRL2, rd);
    check(rd, `ECP_CTRL2_RST);
    reg_rd(4'hf, rd);
    check(rd, 8'h00);
    // all strap pairs first, then random strap-mode pin levels
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      {mode_strap_a_i, mode_strap_b_i} <= (i < 4) ? 2'(3 - i) : {1'b1, rnd[7]};
      {suppressor_enable_pin_i, tone_phase_select_i, code_select_i} <= rnd[2:0];
      {tone_det_a_i, tone_det_b_i} <= rnd[7:6];
      sel_pins <= (i == 3) ? 4'h1 : rnd[6:3];
      repeat (5) @(posedge core_clk_i);
      #1 check(view(), expect_view({1'b0, (i == 3) ? 4'h1 : rnd[6:3], rnd[2:0]}, i == 3));
      check({6'h0, tone_flag_a_n_o, tone_flag_b_n_o}, {6'h0, ~rnd[7:6]});
      @(posedge core_clk_i);
    end
    // controller mode: registers rule, pins other than code select ignored
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      c1 = {4'h0, rnd[3:2], i[1:0]};
      c2 = {6'h0, rnd[5:4]};
      {suppressor_enable_pin_i, tone_phase_select_i, code_select_i} <= rnd[2:0];
      sel_pins <= rnd[6:3] | 4'h1;
      {mode_strap_a_i, mode_strap_b_i} <= 2'b00;
      reg_wr(`ECP_IDX_CTRL1, c1);
      reg_wr(`ECP_IDX_CTRL2, c2);
      repeat (3) @(posedge core_clk_i);
      #1 check(view(), expect_view(rnd, 1'b1));
      @(posedge core_clk_i);
    end
    host_on <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      single_wire_i <= v[0];
      rnd = lfsr(rnd);
      repeat (4) @(posedge core_clk_i);
      ecp_host_i.frame({4'h0, `ECP_IDX_CTRL1}, {4'h0, rnd[3:0]}, 1'b1, rd);
      ecp_host_i.frame({4'h8, `ECP_IDX_CTRL1}, 8'h00, 1'b1, rd);
      check(rd, {4'h0, rnd[3:0]});
      ecp_host_i.frame({4'h0, `ECP_IDX_CTRL1}, {4'h0, ~rnd[3:0]}, 1'b0, rd);
      @(posedge core_clk_i);
      reg_rd(`ECP_IDX_CTRL1, rd);
      check(rd, {4'h0, rnd[3:0]});
    end
    {tone_det_a_i, tone_det_b_i} <= 2'b11;
    standby_reset_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1 check({6'h0, standby_o, tone_flag_a_n_o & tone_flag_b_n_o}, 8'h03);
    @(posedge core_clk_i);
    standby_reset_n_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    reg_rd(`ECP_IDX_CTRL1, rd);
    check(rd, `ECP_CTRL1_RST);
    reg_rd(`ECP_IDX_STATUS, rd);
    check(rd, {4'h0, !code_select_i, 3'h7});
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      pcm_word(i % 2, (i < 2) ? 8'h80 >> (7 * i) : rnd);
    end
    tally_and_finish();
  end
endmodule
